/* File: verilog/adcpt_pkg.sv */
// shared constants and carrier types for the converter control block
package adcpt_pkg;
	// register indices on the plain port
	localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CONFIG      = 4'h1;
	localparam logic [3:0] ADDR_RESULT_HIGH = 4'h2;
	localparam logic [3:0] ADDR_RESULT_LOW  = 4'h3;
	localparam logic [3:0] ADDR_COMPARE_HI  = 4'h4;
	localparam logic [3:0] ADDR_COMPARE_LO  = 4'h5;
	localparam logic [3:0] ADDR_PIN_LOWER   = 4'h6;
	localparam logic [3:0] ADDR_PIN_MIDDLE  = 4'h7;
	localparam logic [3:0] ADDR_PIN_UPPER   = 4'h8;
	localparam logic [3:0] ADDR_STATUS2     = 4'h9;
	// status/control fields
	localparam int SC_DONE_BIT    = 7;
	localparam int SC_IRQEN_BIT   = 6;
	localparam int SC_CONT_BIT    = 5;
	localparam int SC_CH_MSB      = 4;
	localparam int SC2_TRG_BIT    = 7;
	localparam int SC2_CMPEN_BIT  = 6;
	localparam int SC2_GT_BIT     = 5;
	localparam int SC2_ACTIVE_BIT = 4;
	// config fields
	localparam int CFG_DIV_LSB  = 5;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_CLK_LSB  = 0;
	localparam logic [4:0] CH_OFF     = 5'h1f;
	localparam logic [7:0] CFG_RESET  = 8'h00;
	localparam logic [7:0] SC_RESET   = 8'h1f;
	localparam logic [7:0] PIN_RESET  = 8'h00;
	localparam logic [1:0] MODE_8BIT  = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;
	localparam logic [1:0] CLK_BUS    = 2'h0;
	localparam logic [1:0] CLK_BUS2   = 2'h1;
	localparam logic [1:0] CLK_ALT    = 2'h2;
	localparam logic [1:0] CLK_ASYNC  = 2'h3;
	// converter clock cycles per conversion (successive approx steps + overhead)
	localparam logic [4:0] CONV_CYC_8  = 5'h14;
	localparam logic [4:0] CONV_CYC_10 = 5'h17;

	typedef enum logic [1:0] {
		ADCPT_OFF  = 2'b00,
		ADCPT_IDLE = 2'b01,
		ADCPT_CONV = 2'b11
	} adcpt_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} adcpt_bus_t;
endpackage

/* File: verilog/adcpt_top.sv */
// converter control: registers, clock select/divide, trigger, result, pin control
`timescale 1ns/1ps
module adcpt_top #(
	parameter int CH_COUNT = 24
) (
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	// register port
	input  wire adcpt_pkg::adcpt_bus_t   bus,
	output logic [7:0]                   rd_data,
	// external clocks and trigger
	input  wire logic                    alternate_clock,
	input  wire logic                    internal_async_clock,
	input  wire logic                    hw_trigger_input,
	input  wire logic                    low_power_stop,
	// analog front end
	input  wire logic [10:0]             raw_sample,
	output logic                         converter_active,
	output logic [4:0]                   sample_channel,
	// port logic of shared pins
	input  wire logic [CH_COUNT-1:0]     port_pin_in,
	output logic [CH_COUNT-1:0]          port_pin_read,
	output logic [CH_COUNT-1:0]          pin_out_force_off,
	output logic [CH_COUNT-1:0]          pin_pullup_force_off,
	// completion
	output logic                         done_irq
);
	// software-visible state
	logic [7:0]  status_ctrl, next_status_ctrl;
	logic [7:0]  status_ctrl2, next_status_ctrl2;
	logic [7:0]  config_reg, next_config_reg;
	logic [7:0]  pin_control_lower, next_pin_control_lower;
	logic [7:0]  pin_control_middle, next_pin_control_middle;
	logic [7:0]  pin_control_upper, next_pin_control_upper;
	logic [9:0]  compare_value, next_compare_value;
	logic [9:0]  result, next_result;
	logic [7:0]  next_rd_data;
	// conversion state
	adcpt_pkg::adcpt_state_t state, next_state;
	logic [4:0]  conv_count, next_conv_count;
	logic [2:0]  div_count, next_div_count;
	logic        bus_half, next_bus_half;
	logic        alt_q, async_q, next_alt_q, next_async_q;
	logic        trig_q, next_trig_q;
	logic        trig_armed, next_trig_armed;
	logic [CH_COUNT-1:0] next_port_pin_read, next_out_off, next_pull_off;
	logic        next_active;
	logic        next_irq;

	wire logic [4:0] channel_select = status_ctrl[adcpt_pkg::SC_CH_MSB:0];
	wire logic [1:0] input_clock_select  = config_reg[adcpt_pkg::CFG_CLK_LSB +: 2];
	wire logic [1:0] clock_divide_select = config_reg[adcpt_pkg::CFG_DIV_LSB +: 2];
	wire logic [1:0] conv_mode           = config_reg[adcpt_pkg::CFG_MODE_LSB +: 2];
	wire logic       conversion_done_flag = status_ctrl[adcpt_pkg::SC_DONE_BIT];
	wire logic       done_irq_enable      = status_ctrl[adcpt_pkg::SC_IRQEN_BIT];
	wire logic       continuous_mode      = status_ctrl[adcpt_pkg::SC_CONT_BIT];
	wire logic       hw_trigger_select    = status_ctrl2[adcpt_pkg::SC2_TRG_BIT];
	wire logic       compare_enable       = status_ctrl2[adcpt_pkg::SC2_CMPEN_BIT];
	wire logic       compare_greater      = status_ctrl2[adcpt_pkg::SC2_GT_BIT];

	// divide ratio terminal count from the encoded field
	function automatic logic [2:0] div_last(input logic [1:0] sel);
		case (sel)
			2'h0:    div_last = 3'h0;
			2'h1:    div_last = 3'h1;
			2'h2:    div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction

	// round raw result: drop lsb, add it back, saturate at full scale
	function automatic logic [9:0] round_raw(input logic [10:0] raw, input logic ten);
		logic [10:0] sum;
		logic [9:0]  res;
		sum = 11'h000;
		res = 10'h000;
		if (ten) begin
			sum = {1'b0, raw[10:1]} + {10'h000, raw[0]};
			res = sum[10] ? 10'h3ff : sum[9:0];
		end else begin
			sum = {3'h0, raw[8:1]} + {10'h000, raw[0]};
			res = sum[8] ? 10'h0ff : {2'h0, sum[7:0]};
		end
		round_raw = res;
	endfunction

	// source select and divider producing one-cycle converter clock ticks
	logic src_tick;
	logic adc_tick;
	always_comb begin
		next_bus_half = ~bus_half;
		next_alt_q    = alternate_clock;
		next_async_q  = internal_async_clock;
		case (input_clock_select)
			adcpt_pkg::CLK_BUS:  src_tick = 1'b1;
			adcpt_pkg::CLK_BUS2: src_tick = bus_half;
			adcpt_pkg::CLK_ALT:  src_tick = alternate_clock & ~alt_q;
			default:             src_tick = internal_async_clock & ~async_q;
		endcase
		// stop halts every source except the internal async clock
		if (low_power_stop && input_clock_select != adcpt_pkg::CLK_ASYNC)
			src_tick = 1'b0;
		next_div_count = div_count;
		adc_tick = 1'b0;
		if (state != adcpt_pkg::ADCPT_CONV) begin
			next_div_count = 3'h0;
		end else if (src_tick) begin
			if (div_count >= div_last(clock_divide_select)) begin
				next_div_count = 3'h0;
				adc_tick = 1'b1;
			end else begin
				next_div_count = div_count + 3'h1;
			end
		end
	end

	// registers, conversion sequencing, result and pins
	logic        sw_start;
	logic        hw_edge;
	logic        finish;
	logic        cmp_true;
	logic [9:0]  rounded;
	logic [10:0] diff;
	always_comb begin
		next_status_ctrl        = status_ctrl;
		next_status_ctrl2       = status_ctrl2;
		next_config_reg         = config_reg;
		next_pin_control_lower  = pin_control_lower;
		next_pin_control_middle = pin_control_middle;
		next_pin_control_upper  = pin_control_upper;
		next_compare_value      = compare_value;
		next_result             = result;
		next_rd_data            = 8'h00;
		next_state              = state;
		next_conv_count         = conv_count;
		next_trig_q             = hw_trigger_input;
		next_trig_armed         = trig_armed;
		sw_start                = 1'b0;
		finish                  = 1'b0;
		rounded = round_raw(raw_sample, conv_mode == adcpt_pkg::MODE_10BIT);
		diff     = {1'b0, rounded} - {1'b0, compare_value};
		cmp_true = compare_greater ? ~diff[10] : diff[10];
		hw_edge  = hw_trigger_input & ~trig_q;
		if (bus.rd) begin
			case (bus.addr)
				adcpt_pkg::ADDR_STATUS_CTRL: next_rd_data = status_ctrl;
				adcpt_pkg::ADDR_STATUS2:
					next_rd_data = {status_ctrl2[7:5],
						state == adcpt_pkg::ADCPT_CONV, status_ctrl2[3:0]};
				adcpt_pkg::ADDR_CONFIG:      next_rd_data = config_reg;
				adcpt_pkg::ADDR_RESULT_HIGH: next_rd_data = {6'h00, result[9:8]};
				adcpt_pkg::ADDR_RESULT_LOW:  next_rd_data = result[7:0];
				adcpt_pkg::ADDR_COMPARE_HI:  next_rd_data = {6'h00, compare_value[9:8]};
				adcpt_pkg::ADDR_COMPARE_LO:  next_rd_data = compare_value[7:0];
				adcpt_pkg::ADDR_PIN_LOWER:   next_rd_data = pin_control_lower;
				adcpt_pkg::ADDR_PIN_MIDDLE:  next_rd_data = pin_control_middle;
				adcpt_pkg::ADDR_PIN_UPPER:   next_rd_data = pin_control_upper;
				default:                     next_rd_data = 8'h00;
			endcase
		end
		// completion on the last converter clock tick
		if (state == adcpt_pkg::ADCPT_CONV && adc_tick) begin
			if (conv_count == 5'h01) begin
				finish = 1'b1;
				if (!compare_enable || cmp_true) begin
					next_result = compare_enable ? diff[9:0] : rounded;
					next_status_ctrl[adcpt_pkg::SC_DONE_BIT] = 1'b1;
				end
			end
			next_conv_count = conv_count - 5'h01;
		end
		if (finish) begin
			if (continuous_mode || (compare_enable && !cmp_true)) begin
				next_conv_count = (conv_mode == adcpt_pkg::MODE_10BIT) ?
					adcpt_pkg::CONV_CYC_10 : adcpt_pkg::CONV_CYC_8;
			end else begin
				next_state = adcpt_pkg::ADCPT_IDLE;
			end
		end
		// rising edge only honoured when idle and still armed
		if (hw_trigger_select && hw_edge && state == adcpt_pkg::ADCPT_IDLE
				&& trig_armed) begin
			sw_start = 1'b1;
			if (continuous_mode)
				next_trig_armed = 1'b0;
		end
		if (bus.wr) begin
			case (bus.addr)
				adcpt_pkg::ADDR_STATUS_CTRL: begin
					next_status_ctrl = {1'b0, bus.wdata[6:0]};
					next_state = adcpt_pkg::ADCPT_IDLE;
					next_trig_armed = 1'b1;
					sw_start = ~hw_trigger_select;
				end
				adcpt_pkg::ADDR_STATUS2: begin
					next_status_ctrl2 = {bus.wdata[7:5], 1'b0, bus.wdata[3:0]};
					next_state = adcpt_pkg::ADCPT_IDLE;
					next_trig_armed = 1'b1;
					sw_start = 1'b0;
				end
				adcpt_pkg::ADDR_CONFIG: begin
					next_config_reg = bus.wdata;
					next_state = adcpt_pkg::ADCPT_IDLE;
					sw_start = 1'b0;
				end
				adcpt_pkg::ADDR_COMPARE_HI: next_compare_value[9:8] = bus.wdata[1:0];
				adcpt_pkg::ADDR_COMPARE_LO: next_compare_value[7:0] = bus.wdata;
				adcpt_pkg::ADDR_PIN_LOWER:  next_pin_control_lower = bus.wdata;
				adcpt_pkg::ADDR_PIN_MIDDLE: next_pin_control_middle = bus.wdata;
				adcpt_pkg::ADDR_PIN_UPPER:  next_pin_control_upper = bus.wdata;
				default: ;
			endcase
		end else if (bus.rd && bus.addr == adcpt_pkg::ADDR_RESULT_LOW && !finish) begin
			next_status_ctrl[adcpt_pkg::SC_DONE_BIT] = 1'b0;
		end
		if (sw_start) begin
			next_state = adcpt_pkg::ADCPT_CONV;
			next_conv_count = (conv_mode == adcpt_pkg::MODE_10BIT) ?
				adcpt_pkg::CONV_CYC_10 : adcpt_pkg::CONV_CYC_8;
		end
		if (next_status_ctrl[adcpt_pkg::SC_CH_MSB:0] == adcpt_pkg::CH_OFF)
			next_state = adcpt_pkg::ADCPT_OFF;
		else if (next_state == adcpt_pkg::ADCPT_OFF)
			next_state = adcpt_pkg::ADCPT_IDLE;
		next_active = (next_state == adcpt_pkg::ADCPT_CONV);
		next_irq = next_status_ctrl[adcpt_pkg::SC_DONE_BIT] &
			next_status_ctrl[adcpt_pkg::SC_IRQEN_BIT];
		next_out_off  = {next_pin_control_upper, next_pin_control_middle,
			next_pin_control_lower};
		next_pull_off = next_out_off;
		next_port_pin_read = port_pin_in & ~{pin_control_upper, pin_control_middle,
			pin_control_lower};
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ctrl          <= adcpt_pkg::SC_RESET;
			status_ctrl2         <= 8'h00;
			config_reg           <= adcpt_pkg::CFG_RESET;
			pin_control_lower    <= adcpt_pkg::PIN_RESET;
			pin_control_middle   <= adcpt_pkg::PIN_RESET;
			pin_control_upper    <= adcpt_pkg::PIN_RESET;
			compare_value        <= 10'h000;
			result               <= 10'h000;
			rd_data              <= 8'h00;
			state                <= adcpt_pkg::ADCPT_OFF;
			conv_count           <= 5'h00;
			div_count            <= 3'h0;
			bus_half             <= 1'b0;
			alt_q                <= 1'b0;
			async_q              <= 1'b0;
			trig_q               <= 1'b0;
			trig_armed           <= 1'b1;
			converter_active     <= 1'b0;
			sample_channel       <= 5'h00;
			port_pin_read        <= '0;
			pin_out_force_off    <= '0;
			pin_pullup_force_off <= '0;
			done_irq             <= 1'b0;
		end else begin
			status_ctrl          <= next_status_ctrl;
			status_ctrl2         <= next_status_ctrl2;
			config_reg           <= next_config_reg;
			pin_control_lower    <= next_pin_control_lower;
			pin_control_middle   <= next_pin_control_middle;
			pin_control_upper    <= next_pin_control_upper;
			compare_value        <= next_compare_value;
			result               <= next_result;
			rd_data              <= next_rd_data;
			state                <= next_state;
			conv_count           <= next_conv_count;
			div_count            <= next_div_count;
			bus_half             <= next_bus_half;
			alt_q                <= next_alt_q;
			async_q              <= next_async_q;
			trig_q               <= next_trig_q;
			trig_armed           <= next_trig_armed;
			converter_active     <= next_active;
			sample_channel       <= next_status_ctrl[adcpt_pkg::SC_CH_MSB:0];
			port_pin_read        <= next_port_pin_read[CH_COUNT-1:0];
			pin_out_force_off    <= next_out_off[CH_COUNT-1:0];
			pin_pullup_force_off <= next_pull_off[CH_COUNT-1:0];
			done_irq             <= next_irq;
		end
	end
endmodule // adcpt_top

/* File: tb/adcpt_top_props.sv */
// checker for the converter control top ports
`timescale 1ns/1ps
module adcpt_top_props #(
	parameter int CH_COUNT = 24
) (
	// clock and reset
	input wire logic			sys_clk,
	input wire logic			rst_n,
	// register port
	input wire adcpt_pkg::adcpt_bus_t	bus,
	input wire logic [7:0]			rd_data,
	// converter and pins
	input wire logic			converter_active,
	input wire logic [4:0]			sample_channel,
	input wire logic [CH_COUNT-1:0]		port_pin_in,
	input wire logic [CH_COUNT-1:0]		port_pin_read,
	input wire logic [CH_COUNT-1:0]		pin_out_force_off,
	input wire logic [CH_COUNT-1:0]		pin_pullup_force_off,
	input wire logic			done_irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// edges since reset release, saturating; masks the first cycles
	logic [1:0]	up_cnt;
	logic [1:0]	next_up_cnt;
	logic		up;
	always_comb next_up_cnt = (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n) up_cnt <= 2'h0;
		else up_cnt <= next_up_cnt;
	assign up = (up_cnt == 2'h3);

	property p_mid_write;
		up && bus.wr && bus.addr == adcpt_pkg::ADDR_PIN_MIDDLE
			|=> pin_out_force_off[15:8] == $past(bus.wdata);
	endproperty
	a_mid_write: assert property (p_mid_write) else $error("middle pin write lost");
	property p_up_write;
		up && bus.wr && bus.addr == adcpt_pkg::ADDR_PIN_UPPER
			|=> pin_out_force_off[23:16] == $past(bus.wdata);
	endproperty
	a_up_write: assert property (p_up_write) else $error("upper pin write lost");
	property p_pullup;
		up |-> pin_pullup_force_off == pin_out_force_off;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pullup not forced off");
	property p_read_mask;
		up |-> port_pin_read == ($past(port_pin_in) & ~$past(pin_out_force_off));
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("port read not masked");
	property p_idle_read;
		up && !$past(bus.rd) |-> rd_data == 8'h00;
	endproperty
	a_idle_read: assert property (p_idle_read) else $error("read data outside slot");
	property p_mid_read;
		up && bus.rd && bus.addr == adcpt_pkg::ADDR_PIN_MIDDLE
			|=> rd_data == $past(pin_out_force_off[15:8]);
	endproperty
	a_mid_read: assert property (p_mid_read) else $error("middle readback wrong");
	property p_off;
		sample_channel == adcpt_pkg::CH_OFF && $past(sample_channel) == adcpt_pkg::CH_OFF
			|-> !converter_active;
	endproperty
	a_off: assert property (p_off) else $error("active with channel off");
	property p_irq;
		up && done_irq && $past(done_irq) && bus.rd && bus.addr == adcpt_pkg::ADDR_STATUS_CTRL
			|=> rd_data[7:6] == 2'b11;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without flag and enable");
endmodule // adcpt_top_props

bind adcpt_top adcpt_top_props #(.CH_COUNT(CH_COUNT)) props_u (.sys_clk(sys_clk), .rst_n(rst_n),
	.bus(bus), .rd_data(rd_data), .converter_active(converter_active),
	.sample_channel(sample_channel), .port_pin_in(port_pin_in), .port_pin_read(port_pin_read),
	.pin_out_force_off(pin_out_force_off), .pin_pullup_force_off(pin_pullup_force_off),
	.done_irq(done_irq));

/* File: tb/adcpt_pins_model.sv */
// analog pins and front end seen by the converter control block
`timescale 1ns/1ps
module adcpt_pins_model #(
	parameter int		CH_COUNT = 24,
	parameter logic [10:0]	SAMPLE   = 11'h6a5
) (
	// clock
	input wire logic			sys_clk,
	// pin control from the block
	input wire logic [CH_COUNT-1:0]		pin_out_force_off,
	input wire logic [CH_COUNT-1:0]		pin_pullup_force_off,
	// levels toward the block
	output logic [CH_COUNT-1:0]		port_pin_in,
	output logic [10:0]			raw_sample
);
	logic [CH_COUNT-1:0]	pattern = 24'h5a3c96;
	always @(posedge sys_clk) pattern <= pattern + 24'h010101;
	// released pin floats: no pullup, no driver, so show the inverse level
	assign port_pin_in = pattern ^ (pin_out_force_off & pin_pullup_force_off);
	assign raw_sample = SAMPLE;
endmodule // adcpt_pins_model

/* File: tb/adcpt_top_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcpt_top_test;
	localparam logic [10:0]	SAMPLE = 11'h6a5;
	logic			sys_clk = 1'b0;
	logic			rst_n = 1'b0;
	adcpt_pkg::adcpt_bus_t	bus = '0;
	logic			hw_trigger_input = 1'b0;
	logic [7:0]		rd_data;
	logic [10:0]		raw_sample;
	logic			converter_active;
	logic			done_irq;
	logic [4:0]		sample_channel;
	logic [23:0]		port_pin_in, port_pin_read, pin_out_force_off, pin_pullup_force_off;
	logic [9:0]		round8;
	logic [9:0]		round10;
	logic [2:0]		slow_cnt = 3'h0;
	logic			stop_lvl = 1'b0;
	int			waited = 0;
	int			n_errors = 0;
	int			checks_done = 0;
	always #20 sys_clk = ~sys_clk;
	// slow sources: alternate rises every 4 cycles, async every 8
	always @(posedge sys_clk) slow_cnt <= slow_cnt + 3'h1;

	adcpt_top #(.CH_COUNT(24)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
		.rd_data(rd_data), .alternate_clock(slow_cnt[1]), .internal_async_clock(slow_cnt[2]),
		.hw_trigger_input(hw_trigger_input), .low_power_stop(stop_lvl), .raw_sample(raw_sample),
		.converter_active(converter_active), .sample_channel(sample_channel),
		.port_pin_in(port_pin_in), .port_pin_read(port_pin_read),
		.pin_out_force_off(pin_out_force_off), .pin_pullup_force_off(pin_pullup_force_off),
		.done_irq(done_irq));
	adcpt_pins_model #(.CH_COUNT(24), .SAMPLE(SAMPLE)) pins_u (.sys_clk(sys_clk),
		.pin_out_force_off(pin_out_force_off), .pin_pullup_force_off(pin_pullup_force_off),
		.port_pin_in(port_pin_in), .raw_sample(raw_sample));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 chk(rd_data, exp);
	endtask
	task automatic wait_act(input logic lvl, input int lim);
		int took;
		for (took = 0; took < lim && converter_active !== lvl; took++) begin
			@(posedge sys_clk);
			#1;
		end
		waited = took;
		if (took == lim) begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic idle_for(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge sys_clk);
			#1 seen = seen | converter_active;
		end
		chk(seen, 24'h0);
	endtask
	task automatic run_conv(input logic [7:0] sc);
		reg_wr(adcpt_pkg::ADDR_STATUS_CTRL, sc);
		wait_act(1'b1, 4);
		wait_act(1'b0, 400);
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		round8 = ({1'b0, SAMPLE[8:0]} + 10'h001) >> 1;
		round10 = 10'(({1'b0, SAMPLE} + 12'h001) >> 1);
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1 chk(pin_out_force_off, 24'h0);
		reg_rd(adcpt_pkg::ADDR_PIN_MIDDLE, adcpt_pkg::PIN_RESET);
		reg_rd(adcpt_pkg::ADDR_PIN_UPPER, adcpt_pkg::PIN_RESET);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, adcpt_pkg::SC_RESET);
		chk(converter_active, 24'h0);
		for (int i = 0; i < 8; i++) begin
			reg_wr(adcpt_pkg::ADDR_PIN_MIDDLE, 8'h01 << i);
			reg_wr(adcpt_pkg::ADDR_PIN_UPPER, 8'h80 >> i);
			@(posedge sys_clk);
			#1 chk(pin_out_force_off, {8'h80 >> i, 8'h01 << i, 8'h00});
			chk(pin_pullup_force_off, {8'h80 >> i, 8'h01 << i, 8'h00});
			chk(port_pin_read & pin_out_force_off, 24'h0);
			reg_rd(adcpt_pkg::ADDR_PIN_MIDDLE, 8'h01 << i);
		end
		reg_wr(4'hf, 8'hff);
		reg_rd(4'hf, 8'h00);
		reg_rd(adcpt_pkg::ADDR_PIN_UPPER, 8'h01);
		// software start, 8-bit, default bus clock div 1 keeps converter clock in range
		run_conv(8'h43);
		chk(24'(waited), 24'(adcpt_pkg::CONV_CYC_8 - 5'h01));
		chk(sample_channel, 24'h3);
		chk(done_irq, 24'h1);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'hc3);
		reg_rd(adcpt_pkg::ADDR_RESULT_HIGH, 8'h00);
		reg_rd(adcpt_pkg::ADDR_RESULT_LOW, round8[7:0]);
		@(posedge sys_clk);
		#1 chk(done_irq, 24'h0);
		run_conv(8'h03);
		chk(done_irq, 24'h0);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'h83);
		reg_rd(adcpt_pkg::ADDR_RESULT_LOW, round8[7:0]);
		// compare true stores the difference, compare false never completes
		reg_wr(adcpt_pkg::ADDR_COMPARE_HI, 8'h00);
		reg_wr(adcpt_pkg::ADDR_COMPARE_LO, 8'h10);
		reg_wr(adcpt_pkg::ADDR_STATUS2, 8'h60);
		run_conv(8'h03);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'h83);
		reg_rd(adcpt_pkg::ADDR_RESULT_LOW, round8[7:0] - 8'h10);
		reg_wr(adcpt_pkg::ADDR_STATUS2, 8'h40);
		reg_wr(adcpt_pkg::ADDR_STATUS_CTRL, 8'h03);
		repeat (60) @(posedge sys_clk);
		#1 chk(converter_active, 24'h1);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'h03);
		reg_wr(adcpt_pkg::ADDR_STATUS2, 8'h00);
		// 10-bit, bus clock divided by 2
		reg_wr(adcpt_pkg::ADDR_CONFIG, 8'h28);
		run_conv(8'h03);
		chk(24'(waited), 24'(2 * adcpt_pkg::CONV_CYC_10 - 1));
		reg_rd(adcpt_pkg::ADDR_RESULT_HIGH, {6'h00, round10[9:8]});
		reg_rd(adcpt_pkg::ADDR_RESULT_LOW, round10[7:0]);
		reg_rd(adcpt_pkg::ADDR_CONFIG, 8'h28);
		// halved bus clock and alternate clock sources complete
		for (int c = 1; c < 3; c++) begin
			reg_wr(adcpt_pkg::ADDR_CONFIG, 8'(c));
			run_conv(8'h03);
			reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'h83);
		end
		// stop: async source keeps converting, bus source stalls
		@(posedge sys_clk);
		stop_lvl <= 1'b1;
		reg_wr(adcpt_pkg::ADDR_CONFIG, 8'h03);
		run_conv(8'h03);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'h83);
		reg_wr(adcpt_pkg::ADDR_CONFIG, 8'h00);
		reg_wr(adcpt_pkg::ADDR_STATUS_CTRL, 8'h03);
		repeat (40) @(posedge sys_clk);
		#1 chk(converter_active, 24'h1);
		@(posedge sys_clk);
		stop_lvl <= 1'b0;
		wait_act(1'b0, 40);
		reg_rd(adcpt_pkg::ADDR_STATUS_CTRL, 8'h83);
		// hardware trigger: second edge during conversion must not restart
		reg_wr(adcpt_pkg::ADDR_STATUS2, 8'h80);
		reg_wr(adcpt_pkg::ADDR_STATUS_CTRL, 8'h03);
		idle_for(10);
		@(posedge sys_clk);
		hw_trigger_input <= 1'b1;
		wait_act(1'b1, 6);
		repeat (4) @(posedge sys_clk);
		hw_trigger_input <= 1'b0;
		repeat (4) @(posedge sys_clk);
		hw_trigger_input <= 1'b1;
		wait_act(1'b0, 16);
		hw_trigger_input <= 1'b0;
		idle_for(30);
		// channel off ignores triggers
		reg_wr(adcpt_pkg::ADDR_STATUS_CTRL, 8'h1f);
		@(posedge sys_clk);
		hw_trigger_input <= 1'b1;
		idle_for(25);
		wrap_up();
	end
endmodule // adcpt_top_test
